// >>> src/mfp_packer.sv
// Measurement frame packer: samples to headered little-endian byte blocks
`timescale 1ns/10ps
`include "mfp_cfg.svh"

// How it works
// - Once enabled, frames stream out on every sample not flagged by sample_drop, with no request needed.
// - All signals of one sampling instant are captured together as one frame.
// - A block holds a header plus up to the configured number of consecutive frames, capped to what fits one payload.
// - Every block, hence every packet, opens with the header.
// - Configuration is relatched and a new header sent when signals or rate change.
// - Each word is sent least significant byte first.
// - Header is seven words: preamble, order, serial, FFT len, meas len, frames, counter.
// - First header word is the constant 0x41544144.
// - FFT and measurement transfers share the same header layout.
// - Frame count word holds the frames planned for the block, forced to one in FFT mode.
// - Last header word is the running count of processed values.
// - A select mask sets frame content; the active mask is reported back.
// - Signals go out in fixed slot order whatever the selection order.
// - Exposure word is unsigned, clamped to 10 to 100000 tenths of a microsecond.
// - Distance word is signed 32-bit in 10 pm units.
// - State word carries I/O, trigger bits and two-bit LED colour fields.
// - Distance codes 0x7FFFFF00 to 0x7FFFFFFF never carry a valid value.
// - No peak gives distance code 0x7FFFFF04.
// - Peak before range gives 0x7FFFFF05, beyond range gives 0x7FFFFF06.
// - Uncomputable value gives 0x7FFFFF07.
// - Value outside representable range gives 0x7FFFF08.
// - Unselected signals are left out, frame length follows the selection.
module mfp_packer
    import mfp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control
    input wire logic stream_en,
    input mfp_config_type cfg,
    // Samples
    input wire logic sample_valid,
    input mfp_sample_type sample,
    // Byte stream to network stack
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_sop,
    output logic out_eop,
    // Status
    output logic [7:0] active_select,
    output logic sample_drop,
    output logic [31:0] processed_count
);

    // =====================================
    // Reset release
    logic rst_meta_r;
    logic rst_sync_r;
    // Only the second flop feeds the design
    wire rst_n = rst_sync_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // =====================================
    // Helpers
    function automatic logic [3:0] next_slot(input logic [7:0] sel, input logic [3:0] from);
        logic [3:0] res;
        res = 4'h8;
        for (int j = `MFP_SLOTS - 1; j >= 0; j--) begin
            if (sel[j] && (4'(j) >= from)) begin
                res = 4'(j);
            end
        end
        return res;
    endfunction : next_slot

    function automatic logic [3:0] count_sel(input logic [7:0] sel);
        logic [3:0] n;
        n = 4'h0;
        for (int j = 0; j < `MFP_SLOTS; j++) begin
            n = n + {3'h0, sel[j]};
        end
        return n;
    endfunction : count_sel

    // =====================================
    // State
    mfp_fsm_type state_r;
    mfp_fsm_type state_nxt;
    logic [2:0] widx_r;
    logic [2:0] widx_nxt;
    logic [1:0] byte_r;
    logic [1:0] byte_nxt;
    logic [7:0] fcnt_r;
    logic frame_full_r;
    logic [31:0] frame_r [`MFP_SLOTS];
    logic [31:0] cnt_r;
    logic [31:0] cnt_lat_r;
    mfp_config_type cfg_r;

    // =====================================
    // Distance word with error substitution
    // A valid value inside the reserved band gets the range code
    wire in_reserved = ($unsigned(sample.distance) >= `MFP_RSV_LO) &&
                       ($unsigned(sample.distance) <= `MFP_RSV_HI);
    logic [31:0] dist_word;
    always_comb begin
        case (sample.dist_stat)
            MFP_DIST_OK: dist_word = in_reserved ? `MFP_ERR_RANGE : sample.distance;
            MFP_DIST_NO_PEAK: dist_word = `MFP_ERR_NO_PEAK;
            MFP_DIST_BEFORE: dist_word = `MFP_ERR_BEFORE;
            MFP_DIST_BEYOND: dist_word = `MFP_ERR_BEYOND;
            MFP_DIST_NO_CALC: dist_word = `MFP_ERR_NO_CALC;
            MFP_DIST_RANGE: dist_word = `MFP_ERR_RANGE;
            default: dist_word = `MFP_ERR_NO_CALC;
        endcase
    end

    // Exposure clamp
    wire [31:0] expo_word = (sample.exposure < `MFP_EXPO_MIN) ? `MFP_EXPO_MIN :
                            (sample.exposure > `MFP_EXPO_MAX) ? `MFP_EXPO_MAX :
                            sample.exposure;

    // =====================================
    // Transfer bookkeeping
    wire xfer = out_valid && out_ready;
    wire word_end = xfer && (byte_r == 2'h3);
    wire [3:0] slot_next = next_slot(cfg_r.select, {1'b0, widx_r} + 4'h1);
    wire frame_last_word = (slot_next == 4'h8);
    wire frame_done = (state_r == MFP_FRAME) && word_end && frame_last_word;
    wire [3:0] nsel = count_sel(cfg_r.select);

    // Frames that still fit one payload behind the header
    logic [31:0] fit_frames;
    always_comb begin
        case (nsel)
            4'h1: fit_frames = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / 32'h00000004;
            4'h2: fit_frames = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / 32'h00000008;
            4'h3: fit_frames = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / 32'h0000000C;
            4'h4: fit_frames = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / 32'h00000010;
            4'h5: fit_frames = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / 32'h00000014;
            4'h6: fit_frames = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / 32'h00000018;
            4'h7: fit_frames = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / 32'h0000001C;
            4'h8: fit_frames = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / 32'h00000020;
            default: fit_frames = 32'h00000001;
        endcase
    end

    wire [7:0] req_frames = (cfg_r.frames == 8'h00) ? 8'h01 : cfg_r.frames;
    wire [7:0] block_frames = cfg_r.fft_mode ? 8'h01 :
                              (fit_frames < {24'h0, req_frames}) ? fit_frames[7:0] : req_frames;
    wire cfg_changed = (cfg.select != cfg_r.select) || (cfg.rate != cfg_r.rate);
    wire block_tail = (fcnt_r == block_frames - 8'h01) || cfg_changed || !stream_en;
    wire capture = sample_valid && stream_en && (!frame_full_r || frame_done);
    wire block_start = (state_nxt == MFP_HEADER) && (state_r != MFP_HEADER);
    wire [3:0] first_slot = next_slot(cfg_r.select, 4'h0);

    // =====================================
    // Header words
    wire [31:0] frame_bytes = {26'h0, nsel, 2'h0};
    wire [31:0] meas_len = 32'(frame_bytes * {24'h0, block_frames});
    logic [31:0] hdr_word;
    always_comb begin
        case (widx_r)
            3'h0: hdr_word = `MFP_PREAMBLE;
            3'h1: hdr_word = cfg_r.order_num;
            3'h2: hdr_word = cfg_r.serial_num;
            3'h3: hdr_word = cfg_r.fft_mode ? cfg_r.fft_len : 32'h0;
            3'h4: hdr_word = meas_len;
            3'h5: hdr_word = {24'h0, block_frames};
            3'h6: hdr_word = cnt_lat_r;
            default: hdr_word = 32'h0;
        endcase
    end

    // Header words first, then the frame slots in fixed order
    wire [31:0] cur_word = (state_r == MFP_HEADER) ? hdr_word : frame_r[widx_r];
    assign out_data = cur_word[8 * byte_r +: 8];

    // =====================================
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        widx_nxt = widx_r;
        case (state_r)
            MFP_IDLE: begin
                // Wait for a buffered frame and a non-empty selection
                if (stream_en && frame_full_r && (cfg.select != 8'h00)) begin
                    state_nxt = MFP_HEADER;
                    widx_nxt = 3'h0;
                end
            end
            MFP_HEADER: begin
                if (word_end) begin
                    if (widx_r == `MFP_HDR_LAST) begin
                        state_nxt = MFP_FRAME;
                        widx_nxt = first_slot[2:0];
                    end else begin
                        widx_nxt = widx_r + 3'h1;
                    end
                end
            end
            MFP_FRAME: begin
                if (word_end) begin
                    if (!frame_last_word) begin
                        widx_nxt = slot_next[2:0];
                    end else if (block_tail) begin
                        state_nxt = MFP_IDLE;
                    end else begin
                        widx_nxt = first_slot[2:0];
                    end
                end
            end
            default: state_nxt = MFP_IDLE;
        endcase
    end

    // =====================================
    // Stream outputs
    assign out_valid = (state_r == MFP_HEADER) || ((state_r == MFP_FRAME) && frame_full_r);
    assign out_sop = (state_r == MFP_HEADER) && (widx_r == 3'h0) && (byte_r == 2'h0);
    // A cut block still closes on a frame boundary
    assign out_eop = (state_r == MFP_FRAME) && frame_full_r && (byte_r == 2'h3) && frame_last_word &&
                     block_tail;
    assign sample_drop = sample_valid && stream_en && !capture;
    assign active_select = cfg_r.select;
    assign processed_count = cnt_r;

    // Byte index restarts whenever the sequencer changes state
    assign byte_nxt = (state_nxt != state_r) ? 2'h0 : (xfer ? byte_r + 2'h1 : byte_r);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= MFP_IDLE;
            widx_r <= 3'h0;
            byte_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            widx_r <= widx_nxt;
            byte_r <= byte_nxt;
        end
    end

    // Frames sent in this block
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fcnt_r <= 8'h00;
        end else if (block_start) begin
            fcnt_r <= 8'h00;
        end else if (frame_done) begin
            fcnt_r <= fcnt_r + 8'h01;
        end
    end

    // Configuration latched per block
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= '0;
            cnt_lat_r <= 32'h0;
        end else if (block_start) begin
            cfg_r <= cfg;
            cnt_lat_r <= cnt_r;
        end
    end

    // =====================================
    // Frame capture, new sample dropped while a buffered frame has not drained
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_full_r <= 1'b0;
            cnt_r <= 32'h0;
        end else begin
            frame_full_r <= capture || (frame_full_r && !frame_done);
            if (capture) begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int j = 0; j < `MFP_SLOTS; j++) begin
                frame_r[j] <= 32'h0;
            end
        end else if (capture) begin
            frame_r[`MFP_SLOT_DIST] <= dist_word;
            frame_r[`MFP_SLOT_EXPO] <= expo_word;
            frame_r[`MFP_SLOT_ENC1] <= sample.enc_one;
            frame_r[`MFP_SLOT_ENC2] <= sample.enc_two;
            frame_r[`MFP_SLOT_RATE] <= sample.rate;
            frame_r[`MFP_SLOT_TIME] <= sample.time_mark;
            frame_r[`MFP_SLOT_CNT] <= cnt_r;
            frame_r[`MFP_SLOT_STATE] <= sample.state;
        end
    end

endmodule : mfp_packer

// >>> pkg/mfp_cfg.svh
// Constants for the measurement frame packer
`ifndef MFP_CFG_SVH
`define MFP_CFG_SVH

// =====================================
// Header
`define MFP_PREAMBLE 32'h41544144
`define MFP_HDR_WORDS 3'h7
`define MFP_HDR_LAST 3'h6
`define MFP_HDR_BYTES 32'h0000001C

// =====================================
// Largest block, header included, that one payload carries
`define MFP_PAYLOAD_MAX 32'h00000400

// =====================================
// Distance error codes
`define MFP_RSV_LO 32'h7FFFFF00
`define MFP_RSV_HI 32'h7FFFFFFF
`define MFP_ERR_NO_PEAK 32'h7FFFFF04
`define MFP_ERR_BEFORE 32'h7FFFFF05
`define MFP_ERR_BEYOND 32'h7FFFFF06
`define MFP_ERR_NO_CALC 32'h7FFFFF07
`define MFP_ERR_RANGE 32'h07FFFF08

// =====================================
// Exposure limits, tenths of a microsecond
`define MFP_EXPO_MIN 32'h0000000A
`define MFP_EXPO_MAX 32'h000186A0

// =====================================
// Frame slots in fixed order
`define MFP_SLOTS 8
`define MFP_SLOT_LAST 3'h7
`define MFP_SLOT_DIST 0
`define MFP_SLOT_EXPO 1
`define MFP_SLOT_ENC1 2
`define MFP_SLOT_ENC2 3
`define MFP_SLOT_RATE 4
`define MFP_SLOT_TIME 5
`define MFP_SLOT_CNT 6
`define MFP_SLOT_STATE 7

`endif

// >>> pkg/mfp_pkg.sv
// Types for the measurement frame packer
package mfp_pkg;

    typedef enum logic [2:0] {
        MFP_DIST_OK,
        MFP_DIST_NO_PEAK,
        MFP_DIST_BEFORE,
        MFP_DIST_BEYOND,
        MFP_DIST_NO_CALC,
        MFP_DIST_RANGE
    } mfp_dist_stat_type;

    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [13:0] led;
        logic trig_done;
        logic rsv_14;
        logic [5:0] io;
        logic trig_in;
        logic rsv_6;
        logic [5:0] encoder;
    } mfp_state_word_type;

    typedef struct packed {
        logic signed [31:0] distance;
        mfp_dist_stat_type dist_stat;
        logic [31:0] exposure;
        logic [31:0] enc_one;
        logic [31:0] enc_two;
        logic [31:0] rate;
        logic [31:0] time_mark;
        mfp_state_word_type state;
    } mfp_sample_type;

    typedef struct packed {
        logic [7:0] select;
        logic [31:0] rate;
        logic [7:0] frames;
        logic fft_mode;
        logic [31:0] fft_len;
        logic [31:0] order_num;
        logic [31:0] serial_num;
    } mfp_config_type;

    typedef enum logic [1:0] {
        MFP_IDLE,
        MFP_HEADER,
        MFP_FRAME
    } mfp_fsm_type;

endpackage : mfp_pkg

// >>> test/mfp_packer_chk.sv
// Port checker for the measurement frame packer
`timescale 1ns/10ps
`include "mfp_cfg.svh"
module mfp_packer_chk
    import mfp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control and samples
    input wire logic stream_en,
    input mfp_config_type cfg,
    input wire logic sample_valid,
    input mfp_sample_type sample,
    // Byte stream
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic out_sop,
    input wire logic out_eop,
    // Status
    input wire logic [7:0] active_select,
    input wire logic sample_drop,
    input wire logic [31:0] processed_count
);
    // ========
    // Byte index within the block
    logic [15:0] idx_r;
    wire take = out_valid && out_ready;
    wire [15:0] idx_nxt = !take ? idx_r : (out_eop ? 16'h0000 : idx_r + 16'h0001);
    wire [2:0] wsel = idx_r[4:2];
    wire [7:0] req_fr = cfg.frames == 8'h00 ? 8'h01 : cfg.frames;
    wire [31:0] fit_fr = (`MFP_PAYLOAD_MAX - `MFP_HDR_BYTES) / (32'h4 * 32'($countones(active_select)));
    wire [7:0] blk_fr = cfg.fft_mode ? 8'h01 : fit_fr < 32'(req_fr) ? fit_fr[7:0] : req_fr;
    wire [31:0] mlen = 32'($countones(active_select)) * 32'(blk_fr) * 32'h4;
    wire [31:0] hdr_word = wsel == 3'h1 ? cfg.order_num : wsel == 3'h2 ? cfg.serial_num
        : wsel == 3'h3 ? (cfg.fft_mode ? cfg.fft_len : 32'h0) : wsel == 3'h4 ? mlen
        : wsel == 3'h5 ? 32'(blk_fr) : wsel == 3'h6 ? processed_count : 32'h41544144;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            idx_r <= 16'h0000;
        end else begin
            idx_r <= idx_nxt;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_last_taken;
        out_valid && out_ready && out_eop;
    endsequence
    sequence s_stalled;
        out_valid && !out_ready;
    endsequence
    a_hdr_words: assert property (
        out_valid && idx_r < 16'h001C |-> out_data == hdr_word[idx_r[1:0]*8 +: 8])
        else $error("header byte wrong");
    a_sop_first: assert property (
        out_valid |-> out_sop == (idx_r == 16'h0000)) else $error("start marker misplaced");
    a_stall_holds: assert property (
        s_stalled |=> out_valid && $stable(out_data) && $stable(out_sop) && $stable(out_eop))
        else $error("byte changed while stalled");
    a_eop_idle: assert property (
        s_last_taken |=> !out_valid) else $error("no gap after block");
    a_eop_frame_end: assert property (
        out_valid && out_eop |-> idx_r >= 16'h001F
        && (idx_r - 16'h001B) % (4 * $countones(active_select)) == 0) else $error("end marker off frame");
    a_drop_cause: assert property (
        sample_drop |-> sample_valid && stream_en) else $error("drop without sample");
    a_count_step: assert property (
        sample_valid && stream_en && !sample_drop |=> processed_count == $past(processed_count) + 32'h1)
        else $error("count did not step");
    a_count_hold: assert property (
        !sample_valid |=> $stable(processed_count)) else $error("count moved");
    a_sel_latched: assert property (
        out_valid && idx_r == 16'h0001 |-> active_select == cfg.select) else $error("mask not reported");
    a_block_fits: assert property (
        out_valid |-> {16'h0000, idx_r} < `MFP_PAYLOAD_MAX) else $error("block exceeds payload");
endmodule : mfp_packer_chk

bind mfp_packer mfp_packer_chk chk (.ref_clk(ref_clk), .reset_n(reset_n), .stream_en(stream_en),
    .cfg(cfg), .sample_valid(sample_valid), .sample(sample), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop),
    .active_select(active_select), .sample_drop(sample_drop), .processed_count(processed_count));

// >>> test/mfp_sink.sv
// Network stack model taking the byte stream
`timescale 1ns/10ps
module mfp_sink (
    // Clock and pace
    input wire logic ref_clk,
    input wire logic slow,
    // Byte stream
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic out_ready
);
    logic [7:0] got[$];
    logic rdy_r = 1'b1;
    assign out_ready = rdy_r;
    // Slow pace takes every other cycle
    always @(posedge ref_clk) begin
        if (out_valid && out_ready) begin
            got.push_back(out_data);
        end
        rdy_r <= slow ? !rdy_r : 1'b1;
    end
endmodule : mfp_sink

// >>> test/mfp_packer_test.sv
// Testbench for the measurement frame packer
`timescale 1ns/10ps
module mfp_packer_test
    import mfp_pkg::*;
;
    logic ref_clk = 1'b0, reset_n = 1'b0, stream_en = 1'b0, sample_valid = 1'b0, slow = 1'b0;
    logic out_valid, out_ready, out_sop, out_eop, sample_drop;
    logic [7:0] out_data, active_select;
    logic [31:0] processed_count;
    mfp_config_type cfg = '0;
    mfp_sample_type smp = '0;
    logic [7:0] ex[$];
    logic [31:0] codes [6] = '{32'h07FFFF08, 32'h7FFFFF04, 32'h7FFFFF05, 32'h7FFFFF06, 32'h7FFFFF07, 32'h07FFFF08};
    int n_fail = 0, cmp_count = 0, n_drop = 0, npro = 0, cyc = 0, pos = 0;
    initial forever #12.5 ref_clk = ~ref_clk;
    mfp_packer dut (.ref_clk(ref_clk), .reset_n(reset_n), .stream_en(stream_en), .cfg(cfg),
        .sample_valid(sample_valid), .sample(smp), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop), .active_select(active_select),
        .sample_drop(sample_drop), .processed_count(processed_count));
    mfp_sink sink (.ref_clk(ref_clk), .slow(slow), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready));
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (sample_drop === 1'b1) n_drop <= n_drop + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end
    // ========
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) ex.push_back(w[i*8 +: 8]);
    endtask : word
    task automatic header(input logic [31:0] mlen, input logic [31:0] nfr);
        word(32'h41544144);
        word(cfg.order_num);
        word(cfg.serial_num);
        word(cfg.fft_mode ? cfg.fft_len : 32'h0);
        word(mlen);
        word(nfr);
        word(npro + 1);
    endtask : header
    task automatic frame(input logic [31:0] d, input mfp_dist_stat_type st, input logic [31:0] e,
        input logic [31:0] dx, input logic [31:0] ee);
        smp.distance = d;
        smp.dist_stat = st;
        smp.exposure = e;
        smp.time_mark = smp.time_mark + 32'h1;
        if (cfg.select[0]) word(dx);
        if (cfg.select[1]) word(ee);
        if (cfg.select[2]) word(smp.enc_one);
        if (cfg.select[3]) word(smp.enc_two);
        if (cfg.select[4]) word(smp.rate);
        if (cfg.select[5]) word(smp.time_mark);
        if (cfg.select[6]) word(npro);
        if (cfg.select[7]) word(smp.state);
    endtask : frame
    task automatic pulse(input int n);
        sample_valid = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1;
        sample_valid = 1'b0;
        npro++;
    endtask : pulse
    task automatic drain(input int n);
        int i;
        i = 0;
        while (sink.got.size() < n && i < 3000) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
    endtask : drain
    task automatic go(input int n);
        pulse(n);
        drain(ex.size());
    endtask : go
    task automatic flush();
        for (int i = pos; i < ex.size(); i++) check(sink.got[i], ex[i]);
        pos = ex.size();
    endtask : flush
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // ========
    // Tests
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        stream_en = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        cfg.order_num = 32'h0000A1B2;
        cfg.serial_num = 32'h00C3D4E5;
        cfg.fft_len = 32'h00000200;
        cfg.select = 8'h2F;
        cfg.frames = 8'h02;
        smp.enc_one = 32'h00001111;
        smp.enc_two = 32'h00002222;
        slow = 1'b1;
        header(32'h00000028, 32'h00000002);
        frame(32'hFFFFFC18, MFP_DIST_OK, 32'h00000005, 32'hFFFFFC18, 32'h0000000A);
        go(1);
        frame(32'h00000100, MFP_DIST_NO_PEAK, 32'h00030D40, 32'h7FFFFF04, 32'h000186A0);
        go(1);
        flush();
        $display("test 1 done");
        slow = 1'b0;
        cfg.select = 8'h41;
        cfg.frames = 8'h06;
        header(32'h00000030, 32'h00000006);
        for (int k = 0; k < 6; k++) begin
            frame(k == 0 ? 32'h7FFFFF10 : 32'h1, mfp_dist_stat_type'(k), 32'h64, codes[k], 32'h64);
            go(1);
        end
        flush();
        $display("test 2 done");
        slow = 1'b1;
        cfg.fft_mode = 1'b1;
        cfg.select = 8'h90;
        smp.rate = 32'h000003E8;
        smp.state = 32'hC0E40A55;
        header(32'h00000008, 32'h00000001);
        frame(32'h0, MFP_DIST_OK, 32'h64, 32'h0, 32'h64);
        go(3);
        check(n_drop, 32'h00000002);
        flush();
        $display("test 3 done");
        cfg.fft_mode = 1'b0;
        cfg.select = 8'hFF;
        cfg.frames = 8'hFF;
        header(32'h000003E0, 32'h0000001F);
        for (int k = 0; k < 31; k++) begin
            frame(32'h64, MFP_DIST_OK, 32'h50, 32'h64, 32'h50);
            go(1);
        end
        flush();
        $display("payload test done");
        cfg.fft_mode = 1'b0;
        cfg.select = 8'h01;
        cfg.frames = 8'h03;
        header(32'h0000000C, 32'h00000003);
        frame(32'h64, MFP_DIST_OK, 32'h50, 32'h64, 32'h50);
        pulse(1);
        drain(ex.size() - 20);
        cfg.select = 8'h03;
        drain(ex.size());
        header(32'h00000018, 32'h00000003);
        frame(32'h64, MFP_DIST_OK, 32'h50, 32'h64, 32'h50);
        go(1);
        flush();
        check(active_select, 8'h03);
        check(processed_count, npro);
        $display("test 4 done");
        stream_en = 1'b0;
        sample_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        sample_valid = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        check(processed_count, npro);
        check(sink.got.size(), ex.size());
        $display("test 5 done");
        conclude();
    end
endmodule : mfp_packer_test
